// ### verilog/orient_pkg.sv
// package of constants and types for the spindle orientation block
package orient_pkg;
    localparam int          POS_W          = 32;            // position counter width
    localparam int          SPD_W          = 16;            // speed word width, signed
    localparam int          GAIN_W         = 16;            // lock gain width
    localparam int          DIV_W          = 15;            // divisor width
    localparam int          FREQ_W         = 24;            // index frequency word width
    localparam int          CLK_MHZ        = 250;           // system clock rate
    localparam int          ZERO_HOLD_MS   = 400;           // zero speed dwell time
    localparam int          ZERO_HOLD_CYC  = ZERO_HOLD_MS * 1000 * CLK_MHZ;
    localparam int          SLOW_HZ        = 20;            // slowest logic input rate
    localparam int          SLOW_CYC       = (CLK_MHZ * 1000000) / (SLOW_HZ * 4);
    localparam int          GATE_CYC       = CLK_MHZ * 1000000; // one second window
    localparam int          HYST_PER_MILLE = 5;             // 0.5 percent hysteresis
    localparam logic [14:0] DIV_MIN        = 15'h0001;      // smallest divisor
    localparam logic [14:0] DIV_MAX        = 15'h7530;      // 30000, largest divisor
    localparam logic [1:0]  STEP_QUAD      = 2'h1;          // one count per edge, 4 per line
    localparam logic [1:0]  STEP_PDIR      = 2'h1;          // one count per edge, 2 per line

    typedef enum logic [1:0]
    {
        ST_IDLE   = 2'b00,                                  // loop off
        ST_LOCK   = 2'b01,                                  // plain position lock
        ST_ORIENT = 2'b10                                   // orientation on index
    } loop_state_type;
endpackage

// ### verilog/encoder_counter.sv
// encoder edge decoder and bidirectional position counter
module encoder_counter
    import orient_pkg::*;
(
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    input  wire logic             quad_mode_i,
    input  wire logic             chan_a_i,
    input  wire logic             chan_b_i,
    output logic [POS_W-1:0]      count_o
);
    logic             a_d;
    logic             b_d;
    logic [POS_W-1:0] cnt;
    logic [POS_W-1:0] next_cnt;

    // ****************************************************************
    // edge decode
    // ****************************************************************
    always_comb
    begin
        next_cnt = cnt;
        if (quad_mode_i)
        begin
            // any edge of a or b counts: four per line
            if ((chan_a_i ^ a_d) | (chan_b_i ^ b_d))
            begin
                if ((a_d ^ chan_b_i) == 1'b1)
                    next_cnt = cnt + POS_W'(STEP_QUAD);
                else
                    next_cnt = cnt - POS_W'(STEP_QUAD);
            end
        end
        else if (chan_a_i ^ a_d)
        begin
            // pulse edges, b gives direction: two per line
            if (chan_b_i)
                next_cnt = cnt - POS_W'(STEP_PDIR);
            else
                next_cnt = cnt + POS_W'(STEP_PDIR);
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            a_d <= 1'b0;
            b_d <= 1'b0;
            cnt <= '0;
        end
        else
        begin
            a_d <= chan_a_i;
            b_d <= chan_b_i;
            cnt <= next_cnt;
        end
    end

    assign count_o = cnt;
endmodule

// ### verilog/index_freq.sv
// index rising edge detector and frequency meter
module index_freq
    import orient_pkg::*;
(
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    input  wire logic             enable_i,
    input  wire logic             index_i,
    output logic                  rise_o,
    output logic [FREQ_W-1:0]     freq_o
);
    logic              idx_d;
    logic [31:0]       gate;
    logic [31:0]       next_gate;
    logic [FREQ_W-1:0] pulses;
    logic [FREQ_W-1:0] next_pulses;
    logic [FREQ_W-1:0] freq;
    logic [FREQ_W-1:0] next_freq;

    // rising edge is the reference point
    assign rise_o = index_i & ~idx_d;

    // ****************************************************************
    // one second gate, pulses per gate = hertz
    // ****************************************************************
    always_comb
    begin
        next_gate   = gate + 32'h1;
        next_pulses = pulses + (rise_o ? FREQ_W'(1) : FREQ_W'(0));
        next_freq   = freq;
        if (!enable_i)
        begin
            // monitor off with index use off
            next_gate   = '0;
            next_pulses = '0;
            next_freq   = '0;
        end
        else if (gate == 32'(GATE_CYC - 1))
        begin
            next_freq   = next_pulses;   // includes this cycle's edge
            next_gate   = '0;
            next_pulses = '0;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            idx_d  <= 1'b1;          // no false edge if index is high out of reset
            gate   <= '0;
            pulses <= '0;
            freq   <= '0;
        end
        else
        begin
            idx_d  <= index_i;
            gate   <= next_gate;
            pulses <= next_pulses;
            freq   <= next_freq;
        end
    end

    assign freq_o = freq;
endmodule

// ### verilog/spindle_orient.sv
// spindle orientation and zero speed position loop
module spindle_orient
    import orient_pkg::*;
#(
    parameter int HOLD_CYC = ZERO_HOLD_CYC                  // zero speed dwell in clock cycles
)
(
    input  wire logic                    clk_sys_i,
    input  wire logic                    rst_i,
    input  wire logic                    quad_mode_i,
    input  wire logic                    index_input_terminal_i,
    input  wire logic                    encoder_channel_a_terminal_i,
    input  wire logic                    encoder_channel_b_terminal_i,
    input  wire logic signed [SPD_W-1:0] speed_demand_i,
    input  wire logic signed [SPD_W-1:0] speed_feedback_i,
    input  wire logic        [SPD_W-1:0] zero_speed_threshold_i,
    input  wire logic        [GAIN_W-1:0] lock_gain_i,
    input  wire logic                    index_enable_i,
    input  wire logic signed [POS_W-1:0] index_offset_i,
    input  wire logic signed [POS_W-1:0] target_position_i,
    input  wire logic        [DIV_W-1:0] count_divisor_i,
    output logic signed      [POS_W-1:0] position_demand_o,
    output logic                         loop_active_o,
    output logic                         orient_active_o,
    output logic                         target_reached_flag_o,
    output logic             [POS_W-1:0] position_total_o,
    output logic             [POS_W-1:0] position_divided_o,
    output logic             [FREQ_W-1:0] index_frequency_o,
    output logic             [2:0]       shared_logic_inputs_o
);
    logic [POS_W-1:0]        count;
    logic                    idx_rise;
    loop_state_type          state;
    loop_state_type          next_state;
    logic [31:0]             dwell;
    logic [31:0]             next_dwell;
    logic                    dem_low;
    logic                    next_dem_low;
    logic                    fb_low;
    logic                    next_fb_low;
    logic signed [POS_W-1:0] index_pos;
    logic signed [POS_W-1:0] next_index_pos;
    logic signed [POS_W-1:0] base;
    logic signed [POS_W-1:0] next_base;
    logic signed [POS_W-1:0] goal;
    logic signed [POS_W-1:0] target_d;
    logic signed [POS_W-1:0] target_dd;
    logic signed [POS_W-1:0] err;
    logic signed [POS_W-1:0] demand;
    logic signed [POS_W-1:0] next_demand;
    logic                    reached;
    logic                    next_reached;
    logic [POS_W-1:0]        div_q;
    logic [POS_W-1:0]        next_div_q;
    logic [DIV_W-1:0]        div_r;
    logic [DIV_W-1:0]        next_div_r;
    logic [31:0]             slow;
    logic [2:0]              shared;
    logic [2:0]              next_shared;
    logic [DIV_W-1:0]        div_eff;

    // ****************************************************************
    // threshold compare with hysteresis
    // ****************************************************************
    function automatic logic below(input logic signed [SPD_W-1:0] v,
                                   input logic [SPD_W-1:0] th,
                                   input logic was_low);
        logic [SPD_W+9:0] mag;
        logic [SPD_W+9:0] lim;
        mag = (SPD_W+10)'($unsigned(v[SPD_W-1] ? -v : v)) * (SPD_W+10)'(1000);
        // symmetric magnitude, band of plus/minus 0.5 percent
        if (was_low)
            lim = (SPD_W+10)'(th) * (SPD_W+10)'(1000 + HYST_PER_MILLE);
        else
            lim = (SPD_W+10)'(th) * (SPD_W+10)'(1000 - HYST_PER_MILLE);
        return mag < lim;
    endfunction

    encoder_counter u_cnt
    (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .quad_mode_i (quad_mode_i),
        .chan_a_i  (encoder_channel_a_terminal_i),
        .chan_b_i  (encoder_channel_b_terminal_i),
        .count_o   (count)
    );

    index_freq u_idx
    (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .enable_i  (index_enable_i),
        .index_i   (index_input_terminal_i),
        .rise_o    (idx_rise),
        .freq_o    (index_frequency_o)
    );

    // ****************************************************************
    // loop state
    // ****************************************************************
    always_comb
    begin
        next_dem_low   = below(speed_demand_i, zero_speed_threshold_i, dem_low);
        next_fb_low    = below(speed_feedback_i, zero_speed_threshold_i, fb_low);
        next_state     = state;
        next_base      = base;
        next_dwell     = dwell;
        next_index_pos = index_pos;
        if (idx_rise && index_enable_i)
            next_index_pos = $signed(count);
        // dwell counts only while both stay low
        if (dem_low && fb_low)
        begin
            if (dwell < 32'(HOLD_CYC))
                next_dwell = dwell + 32'h1;
        end
        else
            next_dwell = '0;
        case (state)
            ST_IDLE:
            begin
                if (dwell == 32'(HOLD_CYC) && lock_gain_i != '0)
                begin
                    if (index_enable_i)
                    begin
                        next_state = ST_ORIENT;
                        // offset taken once, from last index
                        next_base  = index_pos + index_offset_i;
                    end
                    else
                    begin
                        next_state = ST_LOCK;
                        next_base  = $signed(count);
                    end
                end
            end
            ST_LOCK, ST_ORIENT:
            begin
                // demand, zero gain or index off in orientation releases; feedback ignored
                if (!dem_low || lock_gain_i == '0)
                    next_state = ST_IDLE;
                else if (state == ST_ORIENT && !index_enable_i)
                    next_state = ST_IDLE;
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    // goal: base, plus target in orientation only, signed so sign picks direction
    assign goal = (state == ST_ORIENT) ? base + target_d : base;
    // count independent of feedback source selection
    assign err  = goal - $signed(count);

    // ****************************************************************
    // demand and flag
    // ****************************************************************
    always_comb
    begin
        next_demand  = '0;
        next_reached = reached;
        if (state != ST_IDLE && lock_gain_i != '0)
            next_demand = POS_W'(err * $signed({1'b0, lock_gain_i}));
        if (state == ST_ORIENT)
        begin
            // clear once err reflects a new target; set wins
            if (err == '0)
                next_reached = 1'b1;
            else if (target_d != target_dd)
                next_reached = 1'b0;
        end
        else
            next_reached = 1'b0;
    end

    // ****************************************************************
    // divided count and shared inputs
    // ****************************************************************
    assign div_eff = (count_divisor_i < DIV_MIN) ? DIV_MIN :
                     (count_divisor_i > DIV_MAX) ? DIV_MAX : count_divisor_i;

    always_comb
    begin
        next_div_q  = div_q;
        next_div_r  = div_r;
        next_shared = shared;
        // divided copy counts up once every div_eff changes of running count, either direction
        if (count != position_total_o)
        begin
            if (div_r + DIV_W'(1) >= div_eff)
            begin
                next_div_r = '0;
                next_div_q = div_q + POS_W'(1);
            end
            else
                next_div_r = div_r + DIV_W'(1);
        end
        if (slow == 32'(SLOW_CYC - 1))
            next_shared = {encoder_channel_b_terminal_i, encoder_channel_a_terminal_i,
                           index_input_terminal_i};
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            state            <= ST_IDLE;
            dwell            <= '0;
            dem_low          <= 1'b0;
            fb_low           <= 1'b0;
            index_pos        <= '0;
            base             <= '0;
            target_d         <= '0;
            target_dd        <= '0;
            demand           <= '0;
            reached          <= 1'b0;
            div_q            <= '0;
            div_r            <= '0;
            position_total_o <= '0;
            slow             <= '0;
            shared           <= '0;
        end
        else
        begin
            state            <= next_state;
            dwell            <= next_dwell;
            dem_low          <= next_dem_low;
            fb_low           <= next_fb_low;
            index_pos        <= next_index_pos;
            base             <= next_base;
            target_d         <= target_position_i;
            target_dd        <= target_d;
            demand           <= next_demand;
            reached          <= next_reached;
            div_q            <= next_div_q;
            div_r            <= next_div_r;
            position_total_o <= count;
            slow             <= (slow == 32'(SLOW_CYC - 1)) ? '0 : slow + 32'h1;
            shared           <= next_shared;
        end
    end

    assign position_demand_o     = demand;
    assign loop_active_o         = (state != ST_IDLE);
    assign orient_active_o       = (state == ST_ORIENT);
    assign target_reached_flag_o = reached;
    assign position_divided_o    = div_q;
    assign shared_logic_inputs_o = shared;

    // ****************************************************************
    // checks
    // ****************************************************************
    a_gain_zero_off: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        lock_gain_i == '0 |=> position_demand_o == '0)
        else $error("demand nonzero with zero gain");
    a_demand_release: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (loop_active_o && !dem_low) |=> !loop_active_o)
        else $error("loop not released by demand");
    a_orient_needs_idx: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(orient_active_o) |-> $past(index_enable_i))
        else $error("orientation without index enable");
    a_dwell_before: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(loop_active_o) |-> $past(dwell) == 32'(HOLD_CYC))
        else $error("loop began before dwell");
    a_flag_only_orient: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        target_reached_flag_o |-> $past(orient_active_o))
        else $error("flag outside orientation");
    a_flag_at_goal: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (orient_active_o && err == '0) |=> target_reached_flag_o || !orient_active_o)
        else $error("flag missed at zero error");
    a_freq_off: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !index_enable_i [*2] |-> index_frequency_o == '0)
        else $error("monitor running with index off");
    a_base_held: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (orient_active_o && $past(orient_active_o)) |-> $stable(base))
        else $error("offset reapplied in orientation");
endmodule

// ### sim/encoder_model.sv
// behavioural incremental encoder with index, quadrature or pulse plus direction
module encoder_model
(
    input  wire logic clk_sys_i,
    input  wire logic quad_mode_i,
    output logic      chan_a_o,
    output logic      chan_b_o,
    output logic      index_o
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam int LINES_PER_REV = 16;      // lines between index marks
    int            line_pos;

    initial
    begin
        chan_a_o = 1'b0;
        chan_b_o = 1'b0;
        line_pos = 0;
    end

    // index high for one line per revolution, rising edge is the mark
    assign index_o = (line_pos % LINES_PER_REV) == 0;

    // next quadrature phase {a,b}, channel a leads when moving up
    function automatic logic [1:0] gray_step(input logic [1:0] cur, input bit up);
        case (cur)
            2'h0:    gray_step = up ? 2'h2 : 2'h1;
            2'h2:    gray_step = up ? 2'h3 : 2'h0;
            2'h3:    gray_step = up ? 2'h1 : 2'h2;
            default: gray_step = up ? 2'h0 : 2'h3;
        endcase
    endfunction

    // move whole lines, one level change every gap falling edges
    task automatic move_lines(input int n, input bit up, input int gap);
        logic [1:0] ph;
        for (int i = 0; i < n; i++)
        begin
            if (quad_mode_i)
            begin
                for (int e = 0; e < 4; e++)
                begin
                    ph = gray_step({chan_a_o, chan_b_o}, up);
                    repeat (gap) @(negedge clk_sys_i);
                    chan_a_o = ph[1];
                    chan_b_o = ph[0];
                end
            end
            else
            begin
                repeat (gap) @(negedge clk_sys_i);
                chan_b_o = !up;              // direction level set before the pulse
                repeat (gap) @(negedge clk_sys_i);
                chan_a_o = 1'b1;
                repeat (gap) @(negedge clk_sys_i);
                chan_a_o = 1'b0;
            end
            line_pos += up ? 1 : -1;
        end
    endtask
endmodule

// ### sim/tb.sv
// self-checking bench for the spindle orientation block
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import orient_pkg::*;

    logic                     clk_sys_i = 1'b0;
    logic                     rst_i;
    logic                     quad_mode_i;
    logic                     index_enable_i;
    logic signed [SPD_W-1:0]  speed_demand_i;
    logic signed [SPD_W-1:0]  speed_feedback_i;
    logic        [SPD_W-1:0]  zero_speed_threshold_i;
    logic        [GAIN_W-1:0] lock_gain_i;
    logic signed [POS_W-1:0]  index_offset_i;
    logic signed [POS_W-1:0]  target_position_i;
    logic        [DIV_W-1:0]  count_divisor_i;
    logic signed [POS_W-1:0]  position_demand_o;
    logic                     loop_active_o;
    logic                     orient_active_o;
    logic                     target_reached_flag_o;
    logic        [POS_W-1:0]  position_total_o;
    logic        [POS_W-1:0]  position_divided_o;
    logic        [FREQ_W-1:0] index_frequency_o;
    logic                     chan_a;
    logic                     chan_b;
    logic                     index_pin;
    logic        [31:0]       exp_total;
    int                       errors;
    int                       samples_checked;
    int                       seed;
    int                       sgn;
    int                       changes;
    int                       div;
    int                       n;
    int                       k;
    bit                       up;
    localparam int            HOLD = 64;             // short zero speed dwell keeps the run brief

    // 250 MHz system clock
    always #2 clk_sys_i = ~clk_sys_i;

    encoder_model enc (.clk_sys_i(clk_sys_i), .quad_mode_i(quad_mode_i), .chan_a_o(chan_a),
                       .chan_b_o(chan_b), .index_o(index_pin));

    spindle_orient #(.HOLD_CYC(HOLD)) uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .quad_mode_i(quad_mode_i), .index_input_terminal_i(index_pin),
        .encoder_channel_a_terminal_i(chan_a),
        .encoder_channel_b_terminal_i(chan_b), .speed_demand_i(speed_demand_i),
        .speed_feedback_i(speed_feedback_i), .zero_speed_threshold_i(zero_speed_threshold_i),
        .lock_gain_i(lock_gain_i), .index_enable_i(index_enable_i),
        .index_offset_i(index_offset_i), .target_position_i(target_position_i),
        .count_divisor_i(count_divisor_i), .position_demand_o(position_demand_o),
        .loop_active_o(loop_active_o), .orient_active_o(orient_active_o),
        .target_reached_flag_o(target_reached_flag_o), .position_total_o(position_total_o),
        .position_divided_o(position_divided_o), .index_frequency_o(index_frequency_o),
        .shared_logic_inputs_o());

    // verdict and end of run
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // compare one value against its expectation
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // expected count movement for a run of whole lines
    function automatic int exp_delta(input int lines, input bit dir_up, input bit quad, input int s);
        exp_delta = (quad ? 4 * s : 2) * lines * (dir_up ? 1 : -1);
    endfunction

    // wait bounded for the counters, then compare counters and idle loop outputs
    task automatic settle();
        for (k = 0; k < 20; k++)
        begin
            if (position_total_o === exp_total && position_divided_o === 32'(changes / div))
                break;
            @(negedge clk_sys_i);
        end
        if (k == 20)
        begin
            errors++;
            $display("CHECK FAILED settle_timeout expected %h seen %h", exp_total, position_total_o);
            finish_test();
        end
        check("position_total", position_total_o, exp_total);
        check("position_divided", position_divided_o, 32'(changes / div));
        check("loop_active", {31'h0, loop_active_o}, 32'h0);
        check("orient_active", {31'h0, orient_active_o}, 32'h0);
        check("position_demand", position_demand_o, 32'h0);
    endtask

    // one move of random size and speed, with random loop inputs alongside
    task automatic random_move();
        n = 1 + (($random(seed) & 32'h7fffffff) % 20);
        up = $random(seed) & 1;
        speed_demand_i = 16'((300 + ($random(seed) & 32'h0fff)) * (($random(seed) & 1) ? 1 : -1));
        speed_feedback_i = 16'($random(seed) % 256);
        lock_gain_i = 16'h0001 + 16'($random(seed) & 32'h00ff);
        index_enable_i = $random(seed) & 1;
        index_offset_i = $random(seed);
        target_position_i = $random(seed);
        enc.move_lines(n, up, 2 + ($random(seed) & 3));
        exp_total = exp_total + 32'(exp_delta(n, up, quad_mode_i, sgn));
        changes += (quad_mode_i ? 4 : 2) * n;
        settle();
    endtask

    // zero speed dwell, then loop steps with the encoder held still between them
    task automatic orient_run(input bit use_idx);
        logic signed [31:0] d0;
        logic signed [31:0] e;
        int                 dl;
        speed_demand_i = 16'h0000;
        speed_feedback_i = 16'h0000;
        index_enable_i = use_idx;
        lock_gain_i = 16'h0010;
        index_offset_i = 32'($random(seed) % 256);
        target_position_i = 32'($random(seed) % 256);
        repeat (HOLD + 1) @(negedge clk_sys_i);
        check("loop_early", {31'h0, loop_active_o}, 32'h0);
        @(negedge clk_sys_i);
        check("loop_on", {31'h0, loop_active_o}, 32'h1);
        check("orient_on", {31'h0, orient_active_o}, {31'h0, use_idx});
        @(negedge clk_sys_i);
        d0 = position_demand_o;
        if (!use_idx)
            check("lock_hold", d0, 32'h0);
        dl = exp_delta(2, 1'b1, quad_mode_i, sgn);
        enc.move_lines(2, 1'b1, 2);
        exp_total = exp_total + 32'(dl);
        changes += (quad_mode_i ? 4 : 2) * 2;
        repeat (4) @(negedge clk_sys_i);
        check("loop_demand", position_demand_o, 32'(d0 - dl * 16));
        if (use_idx)
        begin
            e = position_demand_o / 16;
            target_position_i = target_position_i - e;
            repeat (3) @(negedge clk_sys_i);
            check("flag_set", {31'h0, target_reached_flag_o}, 32'h1);
            check("rest_demand", position_demand_o, 32'h0);
            target_position_i = target_position_i + 32'h1;
            index_offset_i = index_offset_i + 32'h5;
            repeat (3) @(negedge clk_sys_i);
            check("flag_clear", {31'h0, target_reached_flag_o}, 32'h0);
            check("offset_once", position_demand_o, 32'h10);
            speed_feedback_i = 16'h0400;
            repeat (4) @(negedge clk_sys_i);
            check("fb_high_hold", {31'h0, orient_active_o}, 32'h1);
        end
        else
        begin
            lock_gain_i = 16'h0000;
            repeat (2) @(negedge clk_sys_i);
            check("gain_zero_off", {31'h0, loop_active_o}, 32'h0);
        end
        speed_demand_i = 16'hfc00;                             // above threshold, reverse sign
        repeat (4) @(negedge clk_sys_i);
        settle();
    endtask

    // hold reset for eight cycles and check that the counters clear
    task automatic do_reset();
        rst_i = 1'b1;
        repeat (8) @(negedge clk_sys_i);
        check("reset_total", position_total_o, 32'h0);
        check("reset_divided", position_divided_o, 32'h0);
        rst_i = 1'b0;
        exp_total = 32'h0;
        changes = 0;
    endtask

    // main sequence
    initial
    begin
        seed = 64;
        rst_i = 1'b1;
        quad_mode_i = 1'b1;
        index_enable_i = 1'b1;
        speed_demand_i = 16'h0400;                     // above threshold until orientation
        speed_feedback_i = 16'h0000;
        zero_speed_threshold_i = 16'h0100;
        lock_gain_i = 16'h0010;
        index_offset_i = 32'h0;
        target_position_i = 32'h0;
        count_divisor_i = 15'h0000;                    // below range, taken as one
        div = 1;
        errors = 0;
        samples_checked = 0;
        sgn = 0;
        do_reset();
        // first line fixes which quadrature order counts up
        enc.move_lines(1, 1'b1, 3);
        for (k = 0; k < 20 && sgn == 0; k++)
        begin
            @(negedge clk_sys_i);
            if (position_total_o === 32'h4)
                sgn = 1;
            else if (position_total_o === 32'hffff_fffc)
                sgn = -1;
        end
        check("quad_first_line", {31'h0, sgn != 0}, 32'h1);
        if (sgn == 0)
            finish_test();
        exp_total = 32'(4 * sgn);
        changes = 4;
        settle();
        // reversal at the fastest spacing
        enc.move_lines(1, 1'b0, 2);
        exp_total = 32'h0;
        changes += 4;
        settle();
        repeat (12) random_move();
        orient_run(1'b1);
        // second reset mid-run, then pulse plus direction with a larger divisor
        do_reset();
        quad_mode_i = 1'b0;
        div = 2 + (($random(seed) & 32'h7fffffff) % 6);
        count_divisor_i = 15'(div);
        repeat (12) random_move();
        orient_run(1'b0);
        check("index_frequency", 32'(index_frequency_o), 32'h0);
        finish_test();
    end
endmodule
